// ==== rtl/eeprom_cmd_pkg.sv ====
// Constants, types and encodings for the serial EEPROM command block.
// Assumes one system clock domain; link pins are sampled, not clocked on.
package eeprom_cmd_pkg;

    // Opcodes with bit 3 masked off
    localparam logic [7:0] OP_MASK        = 8'hf7;
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
    localparam logic [7:0] OP_STAT_READ   = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
    localparam logic [7:0] OP_MEM_READ    = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE   = 8'h02;

    // Status byte field positions
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_LATCH_BIT   = 1;
    localparam int ST_GUARD_LO    = 2;
    localparam int ST_GUARD_HI    = 3;
    localparam int ST_PIN_PROT    = 7;
    localparam logic [7:0] ST_ALL_ONES = 8'hff;

    // Reset values of the protection bits
    localparam logic [1:0] GUARD_RESET    = 2'h0;
    localparam logic       PIN_PROT_RESET = 1'b0;

    // Page geometry
    localparam int PAGE_BITS = 5;

    // Internal program cycle; time in microseconds, clock in MHz
    localparam int PROGRAM_CYCLE_TIME_US = 5000;
    localparam int SYS_CLK_MHZ           = 25;
    localparam int PROGRAM_CYCLES        = PROGRAM_CYCLE_TIME_US * SYS_CLK_MHZ;

    // Link phase
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_OPCODE = 3'b001,
        PH_ADDR   = 3'b011,
        PH_DATA   = 3'b010,
        PH_DEAD   = 3'b110
    } phase_t;

    // Sampled link pins
    typedef struct packed {
        logic sel_n;
        logic sck;
        logic mosi;
        logic wp_n;
    } link_pins_t;

endpackage

// ==== rtl/spi_eeprom_command_protect.sv ====
// Serial EEPROM command interpreter, write-enable latch, status byte,
// addressed reads and page writes with block protection, and pin protection of status writes.
// Assumes link pins come from outside the sys_clk domain; clock mode 0.
`timescale 1ns/1ns

// Contract
// RL1: First byte after select falls is captured as 8-bit opcode.
// RL2: All bytes shift MSB first; transaction starts at select falling edge.
// RL3: Latch set opcode 0000X110, clear opcode 0000X100, bit 3 ignored.
// RL4: Status read 0000X101, status write 0000X001; read returns busy, latch, protection.
// RL5: Memory read 0000X011, memory write 0000X010, bit 3 ignored.
// RL6: Latch is clear at reset, so programming needs a prior set command.
// RL7: Clear-latch command disables programming whatever the protect pin level.
// RL8: Status bit7 pin protect, bits3:2 block guard, bit1 latch, bit0 busy.
// RL9: Bit0 is one only during program cycle; bit1 mirrors the latch.
// RL10: Bits 6:4 read zero when idle; all bits read one while busy.
// RL11: 1K variant guard codes protect none, 300-3FF, 200-3FF, 000-3FF.
// RL12: 2K variant guard codes protect none, 600-7FF, 400-7FF, 000-7FF.
// RL13: Guard and pin protect bits need latch, run timed program cycle.
// RL14: Pin protection when pin low and enable set; refuses status writes.
// RL15: Guarded addresses never programmed; unguarded ones programmable with latch set.
// RL16: Read takes 16-bit address, ignores upper bits and input, streams byte.
// RL17: Read address increments after each byte, wrapping top to zero.
// RL18: Master releases select after the last wanted byte is clocked out.
// RL19: Programming starts only on select rise right after a whole byte.
// RL20: Page write increments five low address bits only, wrapping in page.
// RL21: Busy ignores all but status read; latch clears when cycle ends.
// RL22: Write with latch clear is ignored until next select falling edge.
// RL23: Unknown opcode ignores input, output stays off until next select fall.
// RL24: Protect pin low during select aborts pending status write.
// RL25: Sample input on rising clock, change output on falling, off when deselected.
module spi_eeprom_command_protect
    import eeprom_cmd_pkg::*;
#(
    parameter int ADDR_BITS      = 10,
    parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic sel_n,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic wp_n,
    output logic      miso,
    output logic      miso_oe_n,
    output logic      busy
);
    import eeprom_cmd_pkg::*;

    localparam int DEPTH = 1 << ADDR_BITS;
    localparam int CNT_W = $clog2(PROGRAM_CYCLES_P + 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
    link_pins_t pins_raw;
    link_pins_t s1_ff;
    link_pins_t s2_ff;
    link_pins_t s3_ff;
    link_pins_t pin_ff;
    link_pins_t nxt_pin;
    assign pins_raw = '{sel_n: sel_n, sck: sck, mosi: mosi, wp_n: wp_n};

    always_comb begin
        nxt_pin = pin_ff;
        if (s2_ff.sel_n == s3_ff.sel_n) nxt_pin.sel_n = s3_ff.sel_n;
        if (s2_ff.sck == s3_ff.sck) nxt_pin.sck = s3_ff.sck;
        if (s2_ff.mosi == s3_ff.mosi) nxt_pin.mosi = s3_ff.mosi;
        if (s2_ff.wp_n == s3_ff.wp_n) nxt_pin.wp_n = s3_ff.wp_n;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, wp_n: 1'b1};
            s2_ff  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, wp_n: 1'b1};
            s3_ff  <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, wp_n: 1'b1};
            pin_ff <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, wp_n: 1'b1};
        end else begin
            s1_ff  <= pins_raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // Edge events on the filtered pins
    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    assign sel_fall = pin_ff.sel_n & ~nxt_pin.sel_n; // RL2
    assign sel_rise = ~pin_ff.sel_n & nxt_pin.sel_n;
    assign sck_rise = ~nxt_pin.sel_n & ~pin_ff.sck & nxt_pin.sck; // RL25
    assign sck_fall = ~nxt_pin.sel_n & pin_ff.sck & ~nxt_pin.sck; // RL25

    ////////////////////////////////////////////////////////////////////////
    // Storage array, page buffer and protection decode
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf_ff [1 << PAGE_BITS];
    logic [(1 << PAGE_BITS)-1:0] page_hit_ff;

    // Guarded range: top quarter, top half or all of the array
    function automatic logic guarded(input logic [1:0] g, input logic [ADDR_BITS-1:0] a);
        case (g)
            2'h1:    guarded = &a[ADDR_BITS-1 -: 2]; // RL11 RL12
            2'h2:    guarded = a[ADDR_BITS-1]; // RL11 RL12
            2'h3:    guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command, latch and status state
    phase_t               phase_ff,   nxt_phase;
    logic [7:0]           shift_ff,   nxt_shift;
    logic [2:0]           bit_ff,     nxt_bit;
    logic [7:0]           op_ff,      nxt_op;
    logic                 addr_hi_ff, nxt_addr_hi;
    logic [ADDR_BITS-1:0] addr_ff,    nxt_addr;
    logic                 byte_done_ff, nxt_byte_done;
    logic                 latch_ff,   nxt_latch;
    logic [1:0]           guard_ff,   nxt_guard;
    logic                 pprot_ff,   nxt_pprot;
    logic [7:0]           st_new_ff,  nxt_st_new;
    logic                 st_pend_ff, nxt_st_pend;
    logic                 mem_pend_ff, nxt_mem_pend;
    logic [ADDR_BITS-1:0] page_base_ff, nxt_page_base;
    logic [CNT_W-1:0]     cnt_ff,     nxt_cnt;
    logic [7:0]           out_ff,     nxt_out;
    logic                 oe_n_ff,    nxt_oe_n;
    logic                 page_wr;
    logic [PAGE_BITS-1:0] page_idx;
    logic [7:0]           status_byte;
    logic [7:0]           rx_byte;
    logic                 hw_prot;
    logic [7:0]           opm;

    assign busy    = cnt_ff != '0;
    assign hw_prot = ~pin_ff.wp_n & pprot_ff; // RL14
    assign rx_byte = {shift_ff[6:0], pin_ff.mosi};
    assign opm     = op_ff & OP_MASK;
    assign miso      = out_ff[7];
    assign miso_oe_n = oe_n_ff;

    // Status byte; all ones while programming
    always_comb begin
        status_byte = 8'h00; // RL10
        status_byte[ST_PIN_PROT] = pprot_ff; // RL8
        status_byte[ST_GUARD_HI] = guard_ff[1];
        status_byte[ST_GUARD_LO] = guard_ff[0];
        status_byte[ST_LATCH_BIT] = latch_ff; // RL9
        if (busy) status_byte = ST_ALL_ONES; // RL10 RL9
    end

    // Next-state logic for link, latch and program cycle
    always_comb begin
        nxt_phase     = phase_ff;
        nxt_shift     = shift_ff;
        nxt_bit       = bit_ff;
        nxt_op        = op_ff;
        nxt_addr_hi   = addr_hi_ff;
        nxt_addr      = addr_ff;
        nxt_byte_done = byte_done_ff;
        nxt_latch     = latch_ff;
        nxt_guard     = guard_ff;
        nxt_pprot     = pprot_ff;
        nxt_st_new    = st_new_ff;
        nxt_st_pend   = st_pend_ff;
        nxt_mem_pend  = mem_pend_ff;
        nxt_page_base = page_base_ff;
        nxt_cnt       = cnt_ff;
        nxt_out       = out_ff;
        nxt_oe_n      = oe_n_ff;
        page_wr       = 1'b0;
        page_idx      = addr_ff[PAGE_BITS-1:0];
        // Program cycle countdown
        if (busy) begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == 1) nxt_latch = 1'b0; // RL21
        end
        if (sel_fall) begin
            nxt_phase = PH_OPCODE; // RL1
            nxt_bit = 3'h0;
            nxt_byte_done = 1'b0;
            nxt_st_pend = 1'b0;
            nxt_mem_pend = 1'b0;
        end else if (sel_rise) begin
            nxt_phase = PH_IDLE; // RL22
            nxt_oe_n = 1'b1; // RL25
            // Pending work is spent here, so no stale request outlives its frame
            nxt_st_pend = 1'b0;
            nxt_mem_pend = 1'b0;
            // Start programming only on a byte boundary
            if (byte_done_ff && bit_ff == 3'h0 && !busy) begin // RL19
                if (st_pend_ff && !hw_prot) begin // RL24
                    nxt_guard = st_new_ff[ST_GUARD_HI -: 2]; // RL13
                    nxt_pprot = st_new_ff[ST_PIN_PROT];
                    nxt_cnt   = CNT_W'(PROGRAM_CYCLES_P); // RL13
                end else if (mem_pend_ff) begin
                    nxt_cnt = CNT_W'(PROGRAM_CYCLES_P);
                end
            end
        end else if (phase_ff != PH_IDLE && phase_ff != PH_DEAD) begin
            // Pin protection abort of a pending status write
            if (hw_prot) nxt_st_pend = 1'b0; // RL24
            if (sck_rise) begin
                nxt_shift = rx_byte; // RL2
                nxt_bit = bit_ff + 1'b1;
                nxt_byte_done = 1'b0;
                if (bit_ff == 3'h7) begin
                    nxt_byte_done = 1'b1;
                    case (phase_ff)
                        PH_OPCODE: begin
                            nxt_op = rx_byte; // RL1
                            nxt_addr_hi = 1'b1;
                            nxt_phase = PH_DEAD;
                            case (rx_byte & OP_MASK)
                                OP_SET_LATCH:  if (!busy) nxt_latch = 1'b1; // RL3 RL21
                                OP_CLR_LATCH:  if (!busy) nxt_latch = 1'b0; // RL3 RL7
                                OP_STAT_READ: begin
                                    nxt_phase = PH_DATA; // RL4
                                    nxt_out = status_byte;
                                end
                                OP_STAT_WRITE: if (!busy && latch_ff && !hw_prot) nxt_phase = PH_DATA; // RL14 RL6
                                OP_MEM_READ:   if (!busy) nxt_phase = PH_ADDR; // RL5
                                OP_MEM_WRITE:  if (!busy && latch_ff) nxt_phase = PH_ADDR; // RL22 RL6
                                default:       nxt_phase = PH_DEAD; // RL23
                            endcase
                        end
                        PH_ADDR: begin
                            nxt_addr_hi = 1'b0;
                            if (addr_hi_ff) begin
                                nxt_addr = ADDR_BITS'({rx_byte, addr_ff[7:0]} >> 8); // RL16
                            end else begin
                                nxt_addr = ADDR_BITS'({addr_ff, rx_byte}); // RL16
                                nxt_phase = PH_DATA;
                                if (opm == OP_MEM_READ)
                                    nxt_out = mem[ADDR_BITS'({addr_ff, rx_byte})];
                                else
                                    nxt_page_base = ADDR_BITS'({addr_ff, rx_byte});
                            end
                        end
                        PH_DATA: begin
                            if (opm == OP_STAT_WRITE && !hw_prot) begin
                                nxt_st_new  = rx_byte;
                                nxt_st_pend = 1'b1;
                            end else if (opm == OP_MEM_WRITE) begin
                                page_wr = 1'b1;
                                nxt_mem_pend = 1'b1;
                                nxt_addr[PAGE_BITS-1:0] = addr_ff[PAGE_BITS-1:0] + 1'b1; // RL20
                            end else if (opm == OP_MEM_READ) begin
                                nxt_addr = addr_ff + 1'b1; // RL17
                                nxt_out = mem[addr_ff + 1'b1];
                            end else begin
                                nxt_out = status_byte; // RL4
                            end
                        end
                        default: nxt_phase = PH_DEAD;
                    endcase
                end
            end
            // Output shifts on the falling clock, only in read data phase
            if (sck_fall && phase_ff == PH_DATA && (opm == OP_MEM_READ || opm == OP_STAT_READ)) begin
                if (!oe_n_ff && bit_ff != 3'h0) nxt_out = {out_ff[6:0], 1'b0}; // RL25
                nxt_oe_n = 1'b0;
            end
        end
    end

    // Registers of the command path
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff     <= PH_IDLE;
            shift_ff     <= 8'h00;
            bit_ff       <= 3'h0;
            op_ff        <= 8'h00;
            addr_hi_ff   <= 1'b0;
            addr_ff      <= '0;
            byte_done_ff <= 1'b0;
            latch_ff     <= 1'b0; // RL6
            guard_ff     <= GUARD_RESET;
            pprot_ff     <= PIN_PROT_RESET;
            st_new_ff    <= 8'h00;
            st_pend_ff   <= 1'b0;
            mem_pend_ff  <= 1'b0;
            page_base_ff <= '0;
            cnt_ff       <= '0;
            out_ff       <= 8'h00;
            oe_n_ff      <= 1'b1;
        end else begin
            phase_ff     <= nxt_phase;
            shift_ff     <= nxt_shift;
            bit_ff       <= nxt_bit;
            op_ff        <= nxt_op;
            addr_hi_ff   <= nxt_addr_hi;
            addr_ff      <= nxt_addr;
            byte_done_ff <= nxt_byte_done;
            latch_ff     <= nxt_latch;
            guard_ff     <= nxt_guard;
            pprot_ff     <= nxt_pprot;
            st_new_ff    <= nxt_st_new;
            st_pend_ff   <= nxt_st_pend;
            mem_pend_ff  <= nxt_mem_pend;
            page_base_ff <= nxt_page_base;
            cnt_ff       <= nxt_cnt;
            out_ff       <= nxt_out;
            oe_n_ff      <= nxt_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page buffer, one generate slot per page byte, then the array commit
    logic commit;
    assign commit = sel_rise && byte_done_ff && bit_ff == 3'h0 && !busy && !st_pend_ff && mem_pend_ff;

    genvar gi;
    generate
        for (gi = 0; gi < (1 << PAGE_BITS); gi++) begin : g_page
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    page_buf_ff[gi] <= 8'h00;
                    page_hit_ff[gi] <= 1'b0;
                end else begin
                    if (sel_fall) page_hit_ff[gi] <= 1'b0;
                    else if (page_wr && page_idx == PAGE_BITS'(gi)) begin
                        page_buf_ff[gi] <= rx_byte; // RL20
                        page_hit_ff[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Array commit in one process; guarded bytes are dropped, no reset on the array itself
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < (1 << PAGE_BITS); i++) begin
            if (commit && page_hit_ff[i] && !guarded(guard_ff, {page_base_ff[ADDR_BITS-1:PAGE_BITS], PAGE_BITS'(i)}))
                mem[{page_base_ff[ADDR_BITS-1:PAGE_BITS], PAGE_BITS'(i)}] <= page_buf_ff[i]; // RL15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence wr_start_s;
        sel_rise && byte_done_ff && bit_ff == 3'h0 && !busy && (st_pend_ff && !hw_prot || mem_pend_ff);
    endsequence

    latch_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> !latch_ff) else $error("latch not clear after reset"); // RL6
    busy_all_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy |-> status_byte == ST_ALL_ONES) else $error("status not all ones while busy"); // RL10
    idle_zeros_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !busy |-> status_byte[6:4] == 3'h0 && status_byte[ST_LATCH_BIT] == latch_ff) else $error("idle status bad"); // RL9
    cycle_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_start_s |=> busy && cnt_ff == CNT_W'(PROGRAM_CYCLES_P)) else $error("program cycle not started"); // RL19
    latch_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy && cnt_ff == 1 |=> !latch_ff && !busy) else $error("latch kept after cycle"); // RL21
    out_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin_ff.sel_n |-> miso_oe_n) else $error("output driven while deselected"); // RL25
    hw_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hw_prot && !busy |=> !st_pend_ff) else $error("status write under pin protection"); // RL14
    no_latch_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sck_rise && phase_ff == PH_OPCODE && bit_ff == 3'h7 && ((rx_byte & OP_MASK) == OP_MEM_WRITE) && !latch_ff
        |=> phase_ff == PH_DEAD) else $error("write accepted with latch clear"); // RL22
    pprot_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hw_prot |=> $stable(pprot_ff)) else $error("pin protect changed"); // RL14
endmodule

// ==== test/spi_eeprom_command_protect_tb_top.sv ====
// Self-checking bench for the EEPROM command and protection block.
// Assumes spi_master_model drives the link; sys_clk is 40 ns.
`timescale 1ns/1ns
module spi_eeprom_command_protect_tb_top;
    import eeprom_cmd_pkg::*;
    localparam int CYC = 400;
    logic sys_clk;
    logic rst_n;
    logic wp_n;
    logic sel_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic busy;
    logic drove;
    int   num_errors = 0;
    int   num_checks = 0;
    // 25 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    spi_eeprom_command_protect #(.ADDR_BITS(10), .PROGRAM_CYCLES_P(CYC)) spi_eeprom_command_protect_i (
        .sys_clk, .rst_n, .sel_n, .sck, .mosi, .wp_n, .miso, .miso_oe_n, .busy);
    spi_master_model spi_master_model_i (.sys_clk, .miso, .miso_oe_n, .sel_n, .sck, .mosi, .drove);
    ////////////////////////////////////////
    // Compare one byte-wide result
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Counts, verdict, end of run
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Opcode frame with optional second byte; returns its answer
    task automatic frame2(input logic [7:0] op, input logic [7:0] d, input bit two, output logic [7:0] r);
        spi_master_model_i.start;
        spi_master_model_i.xfer(op, r);
        if (two)
            spi_master_model_i.xfer(d, r);
        spi_master_model_i.stop;
    endtask
    // Memory frame: opcode, 16-bit address, n bytes counting up from d
    task automatic mem(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d, input int n,
                       output logic [7:0] r0, output logic [7:0] r1);
        spi_master_model_i.start;
        spi_master_model_i.xfer(op, r0);
        spi_master_model_i.xfer(a[15:8], r0);
        spi_master_model_i.xfer(a[7:0], r0);
        for (int i = 0; i < n; i++) begin
            spi_master_model_i.xfer(d + 8'(i), r1);
            if (i == 0)
                r0 = r1;
        end
        spi_master_model_i.stop;
    endtask
    // Read the status byte and compare it
    task automatic chk_st(input string what, input logic [7:0] exp);
        logic [7:0] s;
        frame2(OP_STAT_READ, 8'h00, 1'b1, s);
        chk(what, exp, s);
    endtask
    // Bounded wait for the program cycle to end
    task automatic wait_idle;
        for (int n = 0; n < 1000 && busy !== 1'b0; n++)
            @(posedge sys_clk);
        if (busy !== 1'b0) begin
            num_errors++;
            $display("[FAIL] busy expected 0 seen %b", busy);
            final_report;
        end
    endtask
    ////////////////////////////////////////
    // Reset state, refused write, latch opcodes with bit 3 set
    task automatic t_idle;
        logic [7:0] r;
        chk("oe_n idle", 8'h01, {7'h0, miso_oe_n});
        chk_st("status reset", 8'h00);
        mem(OP_MEM_WRITE, 16'h0000, 8'h11, 1, r, r);
        chk("busy no latch", 8'h00, {7'h0, busy});
        frame2(OP_SET_LATCH | 8'h08, 8'h00, 1'b0, r);
        chk_st("status latch", 8'h02);
        frame2(OP_CLR_LATCH | 8'h08, 8'h00, 1'b0, r);
        chk_st("status clear", 8'h00);
        $display("done idle");
    endtask
    // Unknown opcode keeps output off; next frame works
    task automatic t_bad;
        logic [7:0] r;
        frame2(8'h07, 8'h00, 1'b1, r);
        chk("drove on bad op", 8'h00, {7'h0, drove});
        frame2(OP_STAT_READ | 8'h08, 8'h00, 1'b1, r);
        chk("status bit3", 8'h00, r);
        $display("done bad opcode");
    endtask
    // Page wrap, busy status, latch drop, read wrap at top
    task automatic t_page;
        logic [7:0] r0;
        logic [7:0] r1;
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r0);
        mem(OP_MEM_WRITE, 16'hfc1f, 8'h40, 3, r0, r0);
        chk("busy write", 8'h01, {7'h0, busy});
        chk_st("status busy", 8'hff);
        wait_idle;
        chk_st("latch after write", 8'h00);
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r0);
        mem(OP_MEM_WRITE | 8'h08, 16'h03ff, 8'h77, 1, r0, r0);
        wait_idle;
        mem(OP_MEM_READ, 16'h0000, 8'h00, 2, r0, r1);
        chk("page wrap 0", 8'h41, r0);
        chk("page wrap 1", 8'h42, r1);
        mem(OP_MEM_READ | 8'h08, 16'hfbff, 8'h00, 2, r0, r1);
        chk("read top", 8'h77, r0);
        chk("read wrap", 8'h41, r1);
        $display("done page");
    endtask
    // Quarter guard refuses the top byte
    task automatic t_guard;
        logic [7:0] r;
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        frame2(OP_STAT_WRITE, 8'h04, 1'b1, r);
        wait_idle;
        chk_st("guard set", 8'h04);
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        mem(OP_MEM_WRITE, 16'h03ff, 8'h99, 1, r, r);
        wait_idle;
        mem(OP_MEM_READ, 16'h03ff, 8'h00, 1, r, r);
        chk("guarded byte", 8'h77, r);
        $display("done guard");
    endtask
    // Pin protection, clear under pin low, abort mid frame
    task automatic t_hw;
        logic [7:0] r;
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        frame2(OP_STAT_WRITE, 8'h84, 1'b1, r);
        wait_idle;
        chk_st("pin prot set", 8'h84);
        wp_n <= 1'b0;
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        frame2(OP_STAT_WRITE, 8'h00, 1'b1, r);
        wait_idle;
        chk_st("hw refuse", 8'h86);
        frame2(OP_CLR_LATCH, 8'h00, 1'b0, r);
        chk_st("clear wp low", 8'h84);
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        mem(OP_MEM_WRITE, 16'h0000, 8'h55, 1, r, r);
        wait_idle;
        mem(OP_MEM_READ, 16'h0000, 8'h00, 1, r, r);
        chk("unguarded", 8'h55, r);
        wp_n <= 1'b1;
        frame2(OP_SET_LATCH, 8'h00, 1'b0, r);
        spi_master_model_i.start;
        spi_master_model_i.xfer(OP_STAT_WRITE, r);
        spi_master_model_i.xfer(8'h00, r);
        wp_n <= 1'b0;
        spi_master_model_i.stop;
        wp_n <= 1'b1;
        wait_idle;
        chk_st("abort", 8'h86);
        frame2(OP_STAT_WRITE, 8'h00, 1'b1, r);
        wait_idle;
        chk_st("unprotect", 8'h00);
        $display("done pin protect");
    endtask
    // Reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        wp_n  = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_idle;
        t_bad;
        t_page;
        t_guard;
        t_hw;
        final_report;
    end
endmodule

// ==== test/spi_master_model.sv ====
// SPI master model that drives the EEPROM block's link pins.
// Assumes a free-running sys_clk; link timing counts its edges.
`timescale 1ns/1ns
module spi_master_model (
    input  wire logic sys_clk,
    input  wire logic miso,
    input  wire logic miso_oe_n,
    output logic      sel_n,
    output logic      sck,
    output logic      mosi,
    output logic      drove
);
    // Idle link: deselected, clock parked low
    initial begin
        sel_n = 1'b1;
        sck   = 1'b0;
        mosi  = 1'b0;
        drove = 1'b0;
    end
    ////////////////////////////////////////
    // Wait some system clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Frame opens with select falling
    task automatic start;
        sel_n <= 1'b0;
        drove = 1'b0;
        tick(4);
    endtask
    // One byte; sck period 320 ns, 4 clocks a phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            tick(4);
            sck <= 1'b1;
            tick(3);
            // Read late in high phase, one clock before the block acts on the rise
            rx[i] = miso;
            drove = drove | ~miso_oe_n;
            tick(1);
            sck <= 1'b0;
        end
    endtask
    // Select rises in sck low time after a whole byte; mosi toggled
    task automatic stop;
        tick(2);
        sel_n <= 1'b1;
        mosi  <= ~mosi;
        tick(10);
    endtask
endmodule
